// *** hdl/scanner_cfg.svh ***
/*
 * Constants of the sensor matrix change scanner: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef SCANNER_CFG_SVH
`define SCANNER_CFG_SVH

// Matrix geometry and change-word store depth.
`define ROW_COUNT 16
`define COL_COUNT 8
`define FIFO_DEPTH 40

// Byte addresses of the register words.
`define ADDR_DATA 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_DELAY 8'h0C

// Status word bit positions.
`define STAT_FULL_BIT 0
`define STAT_NONEMPTY_BIT 1
`define STAT_FIFO_FULL_BIT 2
`define STAT_PRIMING_BIT 3

// Control word: bit 0 enables scanning.
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1

// Row settle time before the columns are sampled.
`define CLK_MHZ 100
`define SETTLE_NS 100
`define SETTLE_CYCLES ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** hdl/scanner_pkg.sv ***
/*
 * Types shared by the sensor matrix change scanner.
 * Assumes scanner_cfg.svh is on the include path.
 */
package scanner_pkg;
    `include "scanner_cfg.svh"

    // One change word: present state on top, then row and column.
    typedef struct packed {
        logic state;
        logic [3:0] row;
        logic [2:0] col;
    } change_word_type;

    // Scan sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_SELECT = 6'h01,
        ST_SETTLE = 6'h02,
        ST_COMPARE = 6'h04,
        ST_BIT = 6'h08,
        ST_SVC_FULL = 6'h10,
        ST_SVC = 6'h20
    } scan_state_type;
endpackage : scanner_pkg

// *** hdl/sensor_matrix_change_scanner.sv ***
/*
 * Sensor matrix change scanner with an AHB-Lite register slave.
 * Scans 16 rows of 8 switch sensors, reports changes as change words
 * through a one-word output buffer backed by a circular store.
 * Assumes an external 4-to-16 active-low row decoder, pulled-up column
 * returns synchronous to hclk, and a single AHB-Lite master.
 */
`include "scanner_cfg.svh"
// Notes on behaviour
// - Selected row low, closed sensor reads low.
// - 16x8 matrix, 4-bit row, 8 columns parallel.
// - XOR present row with previous row.
// - 16-byte previous map, updated after compare.
// - Reset clears state, then primes whole map.
// - Each change becomes one byte to buffer.
// - Buffer busy: change word goes to store; here every change word goes to the store, and the buffer loads only from it.
// - Store is circular with in/out pointers.
// - Non-empty bit/pin, full flag on pin.
// - Move oldest word during service when buffer is clear.
// - Column counter zero unless row changed.
// - Row and column form the coordinate.
// - Service between successive bit tests.
// - Unchanged row: one service, then next row.
// - Wrap row pointer after whole matrix.
// - Full store stalls until buffer clears.
// - Drain until store empty or buffer full.
// - Present state in change word top bit.
// - Loading sets full flag; master read clears.
module sensor_matrix_change_scanner #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [3:0] row_select,
    input wire logic [7:0] column_in,
    output logic fifo_nonempty_pin,
    output logic word_ready_pin
);
    import scanner_pkg::*;

    localparam int PW = $clog2(DEPTH + 1);

    // Sequencer and scan registers.
    scan_state_type state, next_state;
    logic [4:0] row, next_row; // Five bits so a finished pass is visible.
    logic [3:0] col, next_col; // Counts 8 down to 0 inside a changed row.
    logic [7:0] diff, next_diff; // Compare result of the current row.
    logic [7:0] present, next_present; // Column value just sampled.
    logic priming, next_priming; // High while the map is first filled.
    logic [7:0] wait_cnt, next_wait_cnt;
    // Previous-scan map and circular change-word store.
    logic [7:0] map [0:`ROW_COUNT-1];
    change_word_type fifo_mem [0:DEPTH-1];
    logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, count, next_count;
    // Output buffer and its full flag.
    change_word_type output_data_buffer, next_buffer;
    logic output_full_flag, next_full;
    // Software controls.
    logic enable, next_enable;
    logic [7:0] delay, next_delay;
    // Bus data-phase capture.
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    // Strobes computed combinationally.
    logic push, pop, map_we, master_read;
    change_word_type push_word;

    // Address phase of a valid transfer.
    wire logic take = hsel && hready && htrans[1];

    // Bus side: read data is registered at the address phase, so a data
    // read consumes the buffer at that edge; writes land in the data phase.
    always_comb begin
        next_wr_pend = take && hwrite;
        next_wr_addr = take ? haddr : wr_addr;
        next_enable = enable;
        next_delay = delay;
        next_hrdata = hrdata;
        master_read = take && !hwrite && haddr == `ADDR_DATA;
        if (take && !hwrite) begin
            case (haddr)
                `ADDR_DATA: next_hrdata = {24'h000000, output_data_buffer};
                `ADDR_STATUS: begin
                    next_hrdata = 32'h00000000;
                    next_hrdata[`STAT_FULL_BIT] = output_full_flag;
                    next_hrdata[`STAT_NONEMPTY_BIT] = count != '0;
                    next_hrdata[`STAT_FIFO_FULL_BIT] = count == PW'(DEPTH);
                    next_hrdata[`STAT_PRIMING_BIT] = priming;
                end
                `ADDR_CONTROL: next_hrdata = {31'h00000000, enable};
                `ADDR_DELAY: next_hrdata = {24'h000000, delay};
                default: next_hrdata = 32'h00000000; // Unmapped reads as zero.
            endcase
        end
        if (wr_pend) begin
            // Unmapped writes are ignored, still with an OKAY answer.
            if (wr_addr == `ADDR_CONTROL) begin
                next_enable = hwdata[`CTRL_ENABLE_BIT];
            end else if (wr_addr == `ADDR_DELAY) begin
                next_delay = hwdata[7:0];
            end
        end
    end

    // Bus registers; the slave never inserts wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            enable <= `CTRL_RESET;
            delay <= 8'(`SETTLE_CYCLES);
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            enable <= next_enable;
            delay <= next_delay;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Scan sequencer, store and buffer management.
    always_comb begin
        next_state = state;
        next_row = row;
        next_col = col;
        next_diff = diff;
        next_present = present;
        next_priming = priming;
        next_wait_cnt = wait_cnt;
        push = 1'b0;
        pop = 1'b0;
        map_we = 1'b0;
        push_word = '0;
        case (state)
            ST_SELECT: begin
                if (row == 5'(`ROW_COUNT)) begin
                    next_row = 5'h00;
                    next_priming = 1'b0;
                end else if (enable) begin
                    next_wait_cnt = delay;
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // The row line stands a while before columns are trusted.
                if (wait_cnt == 8'h00) begin
                    next_state = ST_COMPARE;
                end else begin
                    next_wait_cnt = wait_cnt - 8'h01;
                end
            end
            ST_COMPARE: begin
                map_we = 1'b1;
                next_present = column_in;
                next_diff = column_in ^ map[row[3:0]];
                if (priming) begin
                    next_row = row + 5'h01;
                    next_state = ST_SELECT;
                end else if ((column_in ^ map[row[3:0]]) == 8'h00) begin
                    next_col = 4'h0;
                    next_state = ST_SVC_FULL;
                end else begin
                    next_col = 4'(`COL_COUNT);
                    next_state = ST_BIT;
                end
            end
            ST_BIT: begin
                // Service guarantees a free slot before each bit test.
                next_col = col - 4'h1;
                if (diff[col[2:0] - 3'h1]) begin
                    push = 1'b1;
                    push_word.state = present[col[2:0] - 3'h1];
                    push_word.row = row[3:0];
                    push_word.col = col[2:0] - 3'h1;
                end
                next_state = ST_SVC_FULL;
            end
            ST_SVC_FULL: begin
                if (count != PW'(DEPTH)) begin
                    next_state = ST_SVC;
                end else if (!output_full_flag) begin
                    pop = 1'b1;
                    next_state = ST_SVC;
                end
            end
            ST_SVC: begin
                if (count == '0 || output_full_flag) begin
                    if (col != 4'h0) begin
                        next_state = ST_BIT;
                    end else begin
                        next_row = row + 5'h01;
                        next_state = ST_SELECT;
                    end
                end else begin
                    pop = 1'b1;
                end
            end
            default: next_state = ST_SELECT;
        endcase
        // Pointer bookkeeping; both pointers wrap at the store top.
        next_wr_ptr = push ? ((wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + PW'(push) - PW'(pop);
        next_buffer = pop ? fifo_mem[rd_ptr] : output_data_buffer;
        // A load in the same cycle as a master read keeps the flag set.
        next_full = pop ? 1'b1 : (master_read ? 1'b0 : output_full_flag);
    end

    // Sequencer registers; the previous-state map is not reset but filled by priming.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_SELECT;
            row <= 5'h00;
            col <= 4'h0;
            diff <= 8'h00;
            present <= 8'h00;
            priming <= 1'b1;
            wait_cnt <= 8'h00;
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            output_data_buffer <= '0;
            output_full_flag <= 1'b0;
            row_select <= 4'h0;
            fifo_nonempty_pin <= 1'b0;
            word_ready_pin <= 1'b0;
        end else begin
            state <= next_state;
            row <= next_row;
            col <= next_col;
            diff <= next_diff;
            present <= next_present;
            priming <= next_priming;
            wait_cnt <= next_wait_cnt;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            output_data_buffer <= next_buffer;
            output_full_flag <= next_full;
            row_select <= next_row[3:0];
            fifo_nonempty_pin <= next_count != '0;
            word_ready_pin <= next_full;
        end
    end

    // Array storage, written only from the strobes above.
    always_ff @(posedge hclk) begin
        if (map_we) begin
            map[row[3:0]] <= column_in;
        end
        if (push) begin
            fifo_mem[wr_ptr] <= push_word;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Loading the buffer raises the flag and the ready pin.
    load_sets_flag_a: assert property (pop |=> output_full_flag && word_ready_pin)
        else $error("buffer load did not set full flag");
    // A master read without a new load empties the buffer.
    read_clears_flag_a: assert property (master_read && !pop |=> !output_full_flag)
        else $error("master read did not clear full flag");
    // The non-empty pin tracks the store count.
    nonempty_pin_a: assert property (fifo_nonempty_pin == (count != '0))
        else $error("non-empty pin disagrees with store");
    // The ready pin mirrors the full flag.
    ready_pin_a: assert property (word_ready_pin == output_full_flag)
        else $error("ready pin disagrees with full flag");
    // The store is never written while full.
    no_overflow_a: assert property (push |-> count < PW'(DEPTH))
        else $error("push into full store");
    // Change word carries state on top and row, column below.
    word_format_a: assert property (push |-> push_word.row == row[3:0]
        && push_word.state == present[push_word.col])
        else $error("change word malformed");
    // A full store with a busy buffer holds the sequencer.
    full_stall_a: assert property (state == ST_SVC_FULL && count == PW'(DEPTH)
        && output_full_flag |=> state == ST_SVC_FULL)
        else $error("full store did not stall");
    // The decoder sees the row being compared.
    row_drive_a: assert property (state == ST_COMPARE |-> row_select == row[3:0])
        else $error("row select does not match row");
    // An unchanged row skips bit testing with the counter at zero.
    quiet_row_a: assert property (state == ST_COMPARE && !priming
        && (column_in ^ map[row[3:0]]) == 8'h00 |=> state == ST_SVC_FULL && col == 4'h0)
        else $error("unchanged row mishandled");
    // Each bit test uses up one column count and never starts from zero.
    // A bound on the whole row would be wrong: a full store may stall it for as
    // long as the master leaves the buffer unread.
    bits_done_a: assert property (state == ST_BIT |-> col != 4'h0
        ##1 col == $past(col) - 4'h1)
        else $error("column counter misstepped in bit test");

    push_seen_c: cover property (push);
    store_full_c: cover property (count == PW'(DEPTH));
    two_changes_c: cover property (push ##[1:20] push);
    read_word_c: cover property (master_read && output_full_flag);
endmodule : sensor_matrix_change_scanner

// *** sim/matrix_model.sv ***
/*
 * Behavioural 16 by 8 switch matrix that stands behind the row decoder.
 * Assumes row_select drives an active-low 4-to-16 decoder and that the
 * column returns are pulled up; the bench stages changes hierarchically.
 */
module matrix_model (
    input wire logic hclk,
    input wire logic [3:0] row_select,
    output logic [7:0] column_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Present closed contacts, one bit per sensor; all start open.
    logic [7:0] closed [16] = '{default: 8'h00};
    // Next picture staged by the bench.
    logic [7:0] staged [16];
    // Bumped by the bench for each staged picture; only the bench writes it.
    int staged_seq = 0;
    // Sequence number of the last picture applied, copied from staged_seq; only this model writes it.
    int applied_seq = 0;
    // Row seen at the previous edge, to spot the start of a pass.
    logic [3:0] last_row = 4'h0;

    // Only the row held low can pull a return low; a closed contact reads 0.
    assign column_in = ~closed[row_select];

    // Changes land as row 0 is selected, so one whole pass sees them in row order.
    // This keeps the expected order exact at the cost of some latency.
    always @(posedge hclk) begin
        last_row <= row_select;
        if (staged_seq != applied_seq && row_select == 4'h0 && last_row != 4'h0) begin
            foreach (closed[i]) closed[i] <= staged[i];
            applied_seq <= staged_seq;
        end
    end
endmodule : matrix_model

// *** sim/testbench.sv ***
/*
 * Self-checking bench for the sensor matrix change scanner.
 * Assumes the scanner answers AHB-Lite with no wait states and the matrix
 * model applies staged changes at the start of a scan pass.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import scanner_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic fifo_nonempty_pin, word_ready_pin;
    logic [7:0] haddr, column_in;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0] row_select;
    int miscompares, compares, cycles, n;
    // The bench's own picture of the matrix, present and next.
    logic [7:0] cur [16];
    logic [7:0] nxt [16];
    // Change words expected from the scanner, oldest first.
    logic [7:0] exp_q [$];

    sensor_matrix_change_scanner u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .row_select(row_select), .column_in(column_in),
        .fifo_nonempty_pin(fifo_nonempty_pin), .word_ready_pin(word_ready_pin));
    matrix_model u_matrix (.hclk(hclk), .row_select(row_select), .column_in(column_in));

    // A 10 ns clock.
    always #5 hclk = ~hclk;

    // Cuts a hang short; the whole run needs far fewer cycles.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Counts every comparison and reports a mismatch at once.
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    // One single AHB-Lite transfer; the master waits for hready in both phases.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        check("hresp", hresp, 32'h0);
    endtask : bus

    // Hands the next picture to the matrix and predicts the words, row 0 up, column 7 down.
    task commit();
        for (int r = 0; r < 16; r++) begin
            for (int c = 7; c >= 0; c--) begin
                if (nxt[r][c] !== cur[r][c]) exp_q.push_back({~nxt[r][c], r[3:0], c[2:0]});
            end
        end
        foreach (nxt[i]) begin
            u_matrix.staged[i] <= nxt[i];
            cur[i] = nxt[i];
        end
        u_matrix.staged_seq <= u_matrix.staged_seq + 1;
    endtask : commit

    // Reads every expected word, optionally after letting the store fill first.
    task drain(input logic full);
        if (full) begin
            n = 0;
            do begin
                bus(1'b0, 8'h04, 32'h0, rd);
                n++;
            end while (rd[2] !== 1'b1 && n < 400);
            check("status when stalled", rd, 32'h7);
            check("nonempty pin stalled", fifo_nonempty_pin, 1'b1);
        end
        while (exp_q.size() > 0) begin
            n = 0;
            while (word_ready_pin !== 1'b1 && n < 4000) begin
                @(posedge hclk);
                n++;
            end
            check("word ready pin", word_ready_pin, 1'b1);
            bus(1'b0, 8'h00, 32'h0, rd);
            check("change word", rd, {24'h0, exp_q.pop_front()});
        end
        // Long enough for several passes, so any stray word would show.
        repeat (400) @(posedge hclk);
        bus(1'b0, 8'h04, 32'h0, rd);
        check("status idle", rd, 32'h0);
        check("nonempty pin idle", fifo_nonempty_pin, 1'b0);
        check("ready pin idle", word_ready_pin, 1'b0);
    endtask : drain

    // Prints the counts and the verdict, then ends the run.
    task give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Main sequence: reset, registers, random batches, two dense rows, then a full stall.
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 8'h00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        foreach (cur[i]) cur[i] = 8'h00;
        foreach (nxt[i]) nxt[i] = 8'h00;
        void'($urandom(60));
        repeat (6) @(posedge hclk);
        check("ready pin in reset", word_ready_pin, 1'b0);
        hresetn <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, rd);
        check("status priming", rd, 32'h8);
        bus(1'b0, 8'h08, 32'h0, rd);
        check("control reset", rd, 32'h1);
        bus(1'b0, 8'h0C, 32'h0, rd);
        check("delay reset", rd, 32'hA);
        bus(1'b1, 8'h0C, 32'h3, rd);
        bus(1'b1, 8'h10, 32'hFF, rd);
        bus(1'b0, 8'h0C, 32'h0, rd);
        check("delay written", rd, 32'h3);
        bus(1'b0, 8'h10, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        bus(1'b1, 8'h08, 32'h1, rd);
        drain(1'b0);
        $display("test reset and registers done");
        for (int k = 0; k < 6; k++) begin
            repeat ($urandom_range(1, 6)) nxt[$urandom_range(0, 15)][$urandom_range(0, 7)] ^= 1'b1;
            commit();
            drain(1'b0);
        end
        $display("test random changes done");
        nxt[$urandom_range(0, 15)] ^= 8'hFF;
        nxt[$urandom_range(0, 15)] ^= 8'hA5;
        commit();
        drain(1'b0);
        $display("test several changes in a row done");
        foreach (nxt[i]) nxt[i] = ~nxt[i];
        commit();
        drain(1'b1);
        $display("test store full stall done");
        give_verdict();
    end
endmodule : testbench
